// >>> pbe_bus_agent.sv
// far-side bus agents on the pulled-up parity error lines
module pbe_bus_agent (
	// agent requests
	input wire logic pull_pri,
	input wire logic pull_sec,
	// bridge drive
	input wire logic pri_o,
	input wire logic pri_oe,
	input wire logic sec_o,
	input wire logic sec_oe,
	// resolved lines
	output logic pri_pin,
	output logic sec_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pri_pin = ~(pull_pri | (pri_oe & ~pri_o));
	assign sec_pin = ~(pull_sec | (sec_oe & ~sec_o));
endmodule : pbe_bus_agent

// >>> pbe_parity_report.sv
// parity and system error reporting for both bridge interfaces

module pbe_parity_report import pbe_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// configuration enables
	input wire logic pri_perr_resp_en,
	input wire logic sec_perr_resp_en,
	input wire logic serr_en,
	// transaction descriptor
	input wire logic txn_start,
	input wire logic [1:0] txn_type,
	input wire logic txn_dir,
	// data parity checkers and completion phases
	input wire logic pri_data_err,
	input wire logic sec_data_err,
	input wire logic pri_cpl_active,
	input wire logic sec_cpl_active,
	// primary parity error pin
	input wire logic primary_parity_err_n_i,
	output logic primary_parity_err_n_o,
	output logic primary_parity_err_n_oe,
	// secondary parity error pin
	input wire logic secondary_parity_err_n_i,
	output logic secondary_parity_err_n_o,
	output logic secondary_parity_err_n_oe,
	// primary system error pin, open drain
	output logic primary_system_err_n_o,
	output logic primary_system_err_n_oe,
	// status flags
	input wire logic sec_mdpe_clr,
	input wire logic sig_serr_clr,
	output logic sec_master_parity_flag,
	output logic signaled_system_err_flag
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic pbe_drv_t drv_step(input logic fire,
		input pbe_drv_t cur);
		pbe_drv_t nxt;
		nxt = DRV_IDLE;
		if (fire) begin
			nxt = DRV_LOW;
		end else if (cur == DRV_LOW) begin
			nxt = DRV_HIGH;
		end
		return nxt;
	endfunction : drv_step

	// ----------------------------------------------------------------
	// pin synchronisers and transaction descriptor
	// ----------------------------------------------------------------
	logic pri_pin_s1_reg, pri_pin_s1_next;
	logic pri_pin_s2_reg, pri_pin_s2_next;
	logic sec_pin_s1_reg, sec_pin_s1_next;
	logic sec_pin_s2_reg, sec_pin_s2_next;
	logic [1:0] pri_cpl_pipe_reg, pri_cpl_pipe_next;
	logic [1:0] sec_cpl_pipe_reg, sec_cpl_pipe_next;
	logic [1:0] type_reg, type_next;
	logic dir_reg, dir_next;

	always_comb begin
		pri_pin_s1_next = primary_parity_err_n_i;
		pri_pin_s2_next = pri_pin_s1_reg;
		sec_pin_s1_next = secondary_parity_err_n_i;
		sec_pin_s2_next = sec_pin_s1_reg;
		// completion phase delayed to line up with the synchronised pins
		pri_cpl_pipe_next = {pri_cpl_pipe_reg[0], pri_cpl_active};
		sec_cpl_pipe_next = {sec_cpl_pipe_reg[0], sec_cpl_active};
		type_next = type_reg;
		dir_next = dir_reg;
		if (txn_start) begin
			type_next = txn_type;
			dir_next = txn_dir;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pri_pin_s1_reg <= LINE_N_RST;
			pri_pin_s2_reg <= LINE_N_RST;
			sec_pin_s1_reg <= LINE_N_RST;
			sec_pin_s2_reg <= LINE_N_RST;
			pri_cpl_pipe_reg <= PIPE_RST;
			sec_cpl_pipe_reg <= PIPE_RST;
			type_reg <= TXN_TYPE_RST;
			dir_reg <= DIR_RST;
		end else begin
			pri_pin_s1_reg <= pri_pin_s1_next;
			pri_pin_s2_reg <= pri_pin_s2_next;
			sec_pin_s1_reg <= sec_pin_s1_next;
			sec_pin_s2_reg <= sec_pin_s2_next;
			pri_cpl_pipe_reg <= pri_cpl_pipe_next;
			sec_cpl_pipe_reg <= sec_cpl_pipe_next;
			type_reg <= type_next;
			dir_reg <= dir_next;
		end
	end

	// ----------------------------------------------------------------
	// error decisions
	// ----------------------------------------------------------------
	logic down, is_rd, is_pw, is_dw;
	logic pri_pin_seen, sec_pin_seen;
	logic pri_fire, sec_fire, serr_fire;
	logic pri_role, sec_role;
	logic tgt_err_reg, tgt_err_next;

	always_comb begin
		down = (dir_reg == DIR_DOWN);
		is_rd = (type_reg == TXN_READ);
		is_pw = (type_reg == TXN_PWRITE);
		is_dw = (type_reg == TXN_DWRITE);
		// other target's line sampled during our completion
		pri_pin_seen = !pri_pin_s2_reg && pri_cpl_pipe_reg[1];
		sec_pin_seen = !sec_pin_s2_reg && sec_cpl_pipe_reg[1];
		// write target or read initiator on primary
		pri_role = (!down && is_rd) || (down && (is_pw || is_dw));
		// write target or read initiator on secondary
		sec_role = (down && is_rd) || (!down && (is_pw || is_dw));
		pri_fire = pri_perr_resp_en && pri_role
			&& (pri_data_err
			|| (down && is_dw && sec_pin_seen && sec_perr_resp_en));
		sec_fire = sec_perr_resp_en && sec_role
			&& (sec_data_err
			|| (!down && is_dw && pri_pin_seen && pri_perr_resp_en));
		// posted write error on target bus
		serr_fire = serr_en && pri_perr_resp_en && sec_perr_resp_en
			&& is_pw && !tgt_err_reg
			&& ((down && sec_pin_seen) || (!down && pri_pin_seen));
	end

	// ----------------------------------------------------------------
	// line drivers and flags
	// ----------------------------------------------------------------
	pbe_drv_t pri_drv_reg, pri_drv_next;
	pbe_drv_t sec_drv_reg, sec_drv_next;
	logic pri_n_next, pri_oe_next, sec_n_next, sec_oe_next;
	logic serr_n_next, serr_oe_next, mdpe_next, sig_next;

	always_comb begin
		// one low cycle, one high cycle, then release
		pri_drv_next = drv_step(pri_fire, pri_drv_reg);
		sec_drv_next = drv_step(sec_fire, sec_drv_reg);
		pri_n_next = (pri_drv_next != DRV_LOW);
		pri_oe_next = (pri_drv_next != DRV_IDLE);
		sec_n_next = (sec_drv_next != DRV_LOW);
		sec_oe_next = (sec_drv_next != DRV_IDLE);
		// remember an error the bridge caught as posted write target
		tgt_err_next = tgt_err_reg;
		if (txn_start) begin
			tgt_err_next = 1'b0;
		end else if (is_pw && ((down && pri_data_err)
			|| (!down && sec_data_err))) begin
			tgt_err_next = 1'b1;
		end
		serr_n_next = !serr_fire;
		serr_oe_next = serr_fire;
		// master data parity flag, set wins over clear
		mdpe_next = sec_master_parity_flag && !sec_mdpe_clr;
		// pin seen already carries the delayed completion phase
		if (sec_perr_resp_en && down
			&& ((sec_cpl_active && sec_data_err) || sec_pin_seen)) begin
			mdpe_next = 1'b1;
		end
		// signaled system error flag, set wins over clear
		sig_next = signaled_system_err_flag && !sig_serr_clr;
		if (serr_fire) begin
			sig_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pri_drv_reg <= DRV_IDLE;
			sec_drv_reg <= DRV_IDLE;
			tgt_err_reg <= FLAG_RST;
			primary_parity_err_n_o <= LINE_N_RST;
			primary_parity_err_n_oe <= OE_RST;
			secondary_parity_err_n_o <= LINE_N_RST;
			secondary_parity_err_n_oe <= OE_RST;
			primary_system_err_n_o <= LINE_N_RST;
			primary_system_err_n_oe <= OE_RST;
			sec_master_parity_flag <= FLAG_RST;
			signaled_system_err_flag <= FLAG_RST;
		end else begin
			pri_drv_reg <= pri_drv_next;
			sec_drv_reg <= sec_drv_next;
			tgt_err_reg <= tgt_err_next;
			primary_parity_err_n_o <= pri_n_next;
			primary_parity_err_n_oe <= pri_oe_next;
			secondary_parity_err_n_o <= sec_n_next;
			secondary_parity_err_n_oe <= sec_oe_next;
			primary_system_err_n_o <= serr_n_next;
			primary_system_err_n_oe <= serr_oe_next;
			sec_master_parity_flag <= mdpe_next;
			signaled_system_err_flag <= sig_next;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// primary enable gate
	pri_en_gate_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!primary_parity_err_n_o |-> $past(pri_perr_resp_en))
		else $error("primary parity line asserted while disabled");

	sec_en_gate_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!secondary_parity_err_n_o |-> $past(sec_perr_resp_en))
		else $error("secondary parity line asserted while disabled");

	pri_role_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!primary_parity_err_n_o |-> $past(pri_role))
		else $error("primary parity line asserted in wrong role");

	sec_role_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!secondary_parity_err_n_o |-> $past(sec_role))
		else $error("secondary parity line asserted in wrong role");

	pri_data_err_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(pri_data_err && pri_perr_resp_en && pri_role)
		|=> !primary_parity_err_n_o && primary_parity_err_n_oe)
		else $error("primary data parity error not reported");

	sec_read_err_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(sec_data_err && sec_perr_resp_en && down && is_rd)
		|=> !secondary_parity_err_n_o && secondary_parity_err_n_oe)
		else $error("secondary read parity error not reported");

	pri_fwd_dw_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(down && is_dw && sec_pin_seen && pri_perr_resp_en
		&& sec_perr_resp_en) |=> !primary_parity_err_n_o)
		else $error("delayed write error not forwarded to primary");

	sec_fwd_dw_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(!down && is_dw && pri_pin_seen && pri_perr_resp_en
		&& sec_perr_resp_en) |=> !secondary_parity_err_n_o)
		else $error("delayed write error not forwarded to secondary");

	pri_release_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(!primary_parity_err_n_o && !pri_fire)
		|=> (primary_parity_err_n_o && primary_parity_err_n_oe)
		##1 (!primary_parity_err_n_oe || !primary_parity_err_n_o))
		else $error("primary parity line release sequence broken");

	sec_release_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(!secondary_parity_err_n_o && !sec_fire)
		|=> (secondary_parity_err_n_o && secondary_parity_err_n_oe)
		##1 (!secondary_parity_err_n_oe || !secondary_parity_err_n_o))
		else $error("secondary parity line release sequence broken");

	serr_posted_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!primary_system_err_n_o |-> $past(is_pw))
		else $error("system error on non posted transaction");

	serr_perr_en_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!primary_system_err_n_o
		|-> $past(pri_perr_resp_en && sec_perr_resp_en))
		else $error("system error without parity response enables");

	serr_en_gate_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!primary_system_err_n_o |-> $past(serr_en))
		else $error("system error without system error enable");

	serr_no_tgt_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!primary_system_err_n_o |-> !$past(tgt_err_reg))
		else $error("system error after target detected error");

	serr_flag_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!primary_system_err_n_o |-> signaled_system_err_flag)
		else $error("signaled system error flag not set");

	mdpe_cause_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		$rose(sec_master_parity_flag) |-> $past(sec_perr_resp_en && down
		&& (sec_cpl_active || sec_cpl_pipe_reg[1])))
		else $error("master parity flag set without cause");

endmodule : pbe_parity_report

// >>> pbe_parity_report_tb.sv
// self-checking bench for the parity error reporting block
module pbe_parity_report_tb import pbe_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, reset_n, pri_en, sec_en, serr_en, txn_start, txn_dir;
	logic [1:0] txn_type;
	logic pri_err, sec_err, pri_cpl, sec_cpl, mdpe_clr, serr_clr;
	logic pull_pri, pull_sec, pri_pin, sec_pin;
	logic p_o, p_oe, s_o, s_oe, y_o, y_oe, mflag, sflag;
	logic [2:0] exp_q[$];
	logic [2:0] res;
	int err_total, check_count, cyc;

	pbe_parity_report u_dut (
		.clk_sys(clk_sys), .reset_n(reset_n),
		.pri_perr_resp_en(pri_en), .sec_perr_resp_en(sec_en),
		.serr_en(serr_en), .txn_start(txn_start), .txn_type(txn_type),
		.txn_dir(txn_dir), .pri_data_err(pri_err), .sec_data_err(sec_err),
		.pri_cpl_active(pri_cpl), .sec_cpl_active(sec_cpl),
		.primary_parity_err_n_i(pri_pin), .primary_parity_err_n_o(p_o),
		.primary_parity_err_n_oe(p_oe),
		.secondary_parity_err_n_i(sec_pin), .secondary_parity_err_n_o(s_o),
		.secondary_parity_err_n_oe(s_oe),
		.primary_system_err_n_o(y_o), .primary_system_err_n_oe(y_oe),
		.sec_mdpe_clr(mdpe_clr), .sig_serr_clr(serr_clr),
		.sec_master_parity_flag(mflag), .signaled_system_err_flag(sflag)
	);
	pbe_bus_agent u_agent (
		.pull_pri(pull_pri), .pull_sec(pull_sec), .pri_o(p_o),
		.pri_oe(p_oe), .sec_o(s_o), .sec_oe(s_oe),
		.pri_pin(pri_pin), .sec_pin(sec_pin)
	);

	task automatic check(input logic [2:0] got, input logic [2:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic final_report;
		$display("checks=%0d mismatches=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	// ev is {pri_err, sec_err, pull_pri, pull_sec}; result {pri, sec, sys}
	function automatic logic [2:0] want(input logic [1:0] t, input logic d,
		input logic [2:0] en, input logic [3:0] ev);
		logic rd, pw, dw, u;
		rd = t == TXN_READ;
		pw = t == TXN_PWRITE;
		dw = t == TXN_DWRITE;
		u = d == DIR_UP;
		want[2] = en[2] & (ev[3] & (u ? rd : pw | dw) | ev[0] & dw & !u & en[1]);
		want[1] = en[1] & (ev[2] & (u ? pw | dw : rd) | ev[1] & dw & u & en[2]);
		want[0] = &en & pw & (u ? ev[1] : ev[0]);
	endfunction : want

	task automatic txn(input logic [1:0] t, input logic d,
		input logic [2:0] en);
		@(posedge clk_sys);
		txn_start <= 1'b1;
		txn_type <= t;
		txn_dir <= d;
		{pri_en, sec_en, serr_en} <= en;
		@(posedge clk_sys);
		txn_start <= 1'b0;
	endtask : txn

	task automatic hit(input logic [3:0] ev, input logic [2:0] w);
		if (w !== 3'h0) exp_q.push_back(w);
		{pri_err, sec_err, pull_pri, pull_sec} <= ev;
		pri_cpl <= ev[1];
		sec_cpl <= ev[2] | ev[0];
		@(posedge clk_sys);
		{pri_err, sec_err, pull_pri, pull_sec, pri_cpl, sec_cpl} <= 6'h00;
		repeat (6) @(posedge clk_sys);
	endtask : hit

	task automatic flags(input logic [1:0] e);
		check({1'b0, mflag, sflag}, {1'b0, e});
		mdpe_clr <= 1'b1;
		serr_clr <= 1'b1;
		@(posedge clk_sys);
		mdpe_clr <= 1'b0;
		serr_clr <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check({1'b0, mflag, sflag}, 3'h0);
	endtask : flags

	task automatic run(input logic [1:0] t, input logic d,
		input logic [2:0] en, input logic [3:0] ev);
		logic [2:0] w;
		w = want(t, d, en, ev);
		txn(t, d, en);
		hit(ev, w);
		flags({en[1] & d == DIR_DOWN & (ev[2] | ev[0]), w[0]});
	endtask : run

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// result monitor and hang guard
	always @(posedge clk_sys) begin
		res = {~p_o & p_oe, ~s_o & s_oe, ~y_o & y_oe};
		if (reset_n === 1'b1 && res !== 3'h0) begin
			if (exp_q.size() == 0) check(res, 3'h0);
			else check(res, exp_q.pop_front());
		end
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			final_report();
		end
	end

	initial begin
		{reset_n, pri_en, sec_en, serr_en, txn_start, txn_dir} = 6'h00;
		txn_type = 2'h0;
		{pri_err, sec_err, pri_cpl, sec_cpl} = 4'h0;
		{mdpe_clr, serr_clr, pull_pri, pull_sec} = 4'h0;
		err_total = 0;
		check_count = 0;
		cyc = 0;
		void'($urandom(32'he2ce));
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		check({p_oe, s_oe, y_oe}, 3'h0);
		check({p_o, s_o, y_o}, 3'h7);
		for (int i = 0; i < 64; i++) begin
			run(i[3:2], i[1], i[4] ? 3'h7 : 3'($urandom()), i[0] ? 4'h4 : 4'h8);
		end
		$display("data error test done");
		for (int i = 0; i < 64; i++) begin
			run(i[3:2], i[1], i[4] ? 3'h7 : 3'($urandom()), i[0] ? 4'h2 : 4'h1);
		end
		$display("pin seen test done");
		for (int i = 0; i < 2; i++) begin
			txn(TXN_PWRITE, i[0], 3'h7);
			hit(i[0] ? 4'h4 : 4'h8, i[0] ? 3'h2 : 3'h4);
			hit(i[0] ? 4'h2 : 4'h1, 3'h0);
			flags({~i[0], 1'b0});
		end
		$display("target detect test done");
		check(3'(exp_q.size()), 3'h0);
		final_report();
	end
endmodule : pbe_parity_report_tb

// >>> pbe_pkg.sv
// shared constants and types for the bridge parity error reporting block
package pbe_pkg;

	// ----------------------------------------------------------------
	// transaction descriptor encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] TXN_READ = 2'h0;
	localparam logic [1:0] TXN_PWRITE = 2'h1;
	localparam logic [1:0] TXN_DWRITE = 2'h2;
	localparam logic DIR_DOWN = 1'b0;
	localparam logic DIR_UP = 1'b1;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic LINE_N_RST = 1'b1;
	localparam logic OE_RST = 1'b0;
	localparam logic FLAG_RST = 1'b0;
	localparam logic [1:0] TXN_TYPE_RST = 2'h0;
	localparam logic DIR_RST = 1'b0;
	localparam logic [1:0] PIPE_RST = 2'h0;

	// ----------------------------------------------------------------
	// error line drive sequence
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DRV_IDLE = 2'b00,
		DRV_LOW = 2'b01,
		DRV_HIGH = 2'b10
	} pbe_drv_t;

endpackage : pbe_pkg
